// ==== rtl/usf_params.svh ====
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH

// register indices on the plain register port
`define USF_ADDR_MODE 4'h0
`define USF_ADDR_STATUS 4'h1
`define USF_ADDR_TXDATA 4'h2
`define USF_ADDR_RXDATA 4'h3
`define USF_ADDR_DIVISOR 4'h4

// reset values and writable masks
`define USF_MODE_RESET 16'h0000
`define USF_STATUS_RESET 16'h0000
`define USF_DIVISOR_RESET 16'h0000
`define USF_MODE_WMASK 16'hbbff
`define USF_STATUS_WMASK 16'hece0

// serial_mode_config fields
`define USF_M_ENABLE 15
`define USF_M_INFRARED 12
`define USF_M_PINS_HI 9
`define USF_M_PINS_LO 8
`define USF_M_LOOPBACK 6
`define USF_M_AUTOBAUD 5
`define USF_M_RXINV 4
`define USF_M_HISPEED 3
`define USF_M_PD_HI 2
`define USF_M_PD_LO 1
`define USF_M_TWOSTOP 0

// serial_status_control fields
`define USF_S_TXI_HI 15
`define USF_S_TXINV 14
`define USF_S_TXI_LO 13
`define USF_S_BREAK 11
`define USF_S_TXEN 10
`define USF_S_RXI_HI 7
`define USF_S_RXI_LO 6
`define USF_S_ADDRDET 5
`define USF_S_OVERRUN 1

// format and mode encodings
`define USF_PD_NINE 2'b11
`define USF_PD_ODD 2'b10
`define USF_PD_EVEN 2'b01
`define USF_PD_PLAIN 2'b00
`define USF_TXI_EMPTY 2'b10
`define USF_TXI_DONE 2'b01
`define USF_TXI_EACH 2'b00
`define USF_RXI_FULL 2'b11
`define USF_RXI_3Q 2'b10

// counts
`define USF_OS_HIGH 5'd4
`define USF_OS_STD 5'd16
`define USF_BREAK_ZEROS 12
`define USF_BREAK_LEN 4'd14
`define USF_FIFO_DEPTH 4
`define USF_RX_THR_FULL 4
`define USF_RX_THR_3Q 3
`define USF_IR_PULSE 5'd3
`define USF_IR_HOLD 4'hf
`define USF_SYNC_FALLS 3'd5
`define USF_SYNC_SHIFT_HIGH 5
`define USF_SYNC_SHIFT_STD 7

`endif

// ==== rtl/usf_pkg.sv ====
package usf_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SHIFT = 2'b10
	} usf_tx_state_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_START = 3'b010,
		RX_DATA = 3'b100
	} usf_rx_state_t;
endpackage

// ==== rtl/usf_fifo.sv ====
module usf_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		// wraps at any depth, not only powers of two
		return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	wire do_push = in_valid && in_ready;
	wire do_pop = out_valid && out_ready;

	assign in_ready = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign count = cnt_q;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || flush)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_push)
				wr_q <= next_ptr(wr_q);
			if (do_pop)
				rd_q <= next_ptr(rd_q);
			cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (do_push)
			mem_q[wr_q] <= in_data;
	end
endmodule

// ==== rtl/usf_top.sv ====
`include "usf_params.svh"

// Behaviour
// RULE1: receive inversion picks idle receive level
// RULE2: high speed gives 4x, else 16x
// RULE3: two-bit field selects data width, parity
// RULE4: stop select gives two or one stops
// RULE5: infrared codec only in 16x mode
// RULE6: transmit interrupt on empty, done, each
// RULE7: transmit inversion flips plain or infrared idle
// RULE8: break sends start, twelve zeros, stop
// RULE9: transmit disable aborts, flushes, releases pin
// RULE10: buffer full flag when no room
// RULE11: transmitter empty when shifter and buffer empty
// RULE12: receive interrupt at four, three, any
// RULE13: address detect keeps ninth-bit-set characters only
// RULE14: receiver idle flag, high at reset
// RULE15: parity error of head character
// RULE16: framing error of head character
// RULE17: overrun set on overflow, clearing flushes receiver
// RULE18: data available while receive buffer nonempty
// RULE19: both directions use four-deep queues
// RULE20: auto-baud measures 55h sync, then clears
// RULE21: module disable releases pins, idles logic
// RULE22: loopback feeds transmit line into receiver
// RULE23: start on leaving idle, centre sampling
// RULE24: missing stop bit flags framing error
module usf_top #(
	parameter int FIFO_DEPTH = `USF_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [15:0] reg_rdata,
	// serial pins
	input wire logic rx_pin_i,
	output logic tx_pin_o,
	output logic tx_pin_oe,
	output logic rx_pin_owned,
	output logic [1:0] pin_enable_field,
	// events
	output logic tx_irq,
	output logic rx_irq
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	logic [15:0] serial_mode_config_q, serial_mode_config_d;
	logic [15:0] serial_status_control_q, serial_status_control_d;
	logic [15:0] divisor_q, divisor_d;
	logic [15:0] bcnt_q;
	logic [15:0] rd_word;
	logic [15:0] rdata_q;
	usf_pkg::usf_tx_state_t tx_st_q, tx_st_d;
	usf_pkg::usf_rx_state_t rx_st_q, rx_st_d;
	logic [4:0] tx_os_q, rx_os_q;
	logic [3:0] tx_bit_q, tx_len_q, rx_bit_q, ir_hold_q;
	logic [14:0] tx_sh_q;
	logic [8:0] rx_sh_q;
	logic tx_brk_q, tx_pin_q, tx_oe_q, tx_irq_q, rx_irq_q, rx_prev_q, overrun_q;
	logic [2:0] ab_falls_q;
	logic [23:0] ab_cnt_q;
	logic tx_fifo_valid, tx_in_ready, rx_fifo_valid, rx_in_ready;
	logic [8:0] tx_head;
	logic [10:0] rx_head;
	logic [CW-1:0] tx_count, rx_count;

	function automatic logic calc_parity(input logic [7:0] d, input logic odd);
		return odd ? ~^d : ^d;
	endfunction

	// bit 0 leaves first; unused top bits stay at stop level
	function automatic logic [14:0] build_frame(input logic [8:0] d, input logic [1:0] pd,
		input logic brk);
		logic [14:0] f;
		f = 15'h7ffe;
		if (brk)
			f = {2'b11, {`USF_BREAK_ZEROS{1'b0}}, 1'b0};
		else if (pd == `USF_PD_NINE)
			f[9:1] = d;
		else
		begin
			f[8:1] = d[7:0];
			if (pd != `USF_PD_PLAIN)
				f[9] = calc_parity(d[7:0], pd == `USF_PD_ODD);
		end
		return f;
	endfunction

	function automatic logic [3:0] frame_len(input logic [1:0] pd, input logic two, input logic brk);
		logic [3:0] body;
		body = (pd == `USF_PD_PLAIN) ? 4'd9 : 4'd10;
		return brk ? `USF_BREAK_LEN : body + (two ? 4'd2 : 4'd1);
	endfunction

	// configuration fields
	wire module_enable = serial_mode_config_q[`USF_M_ENABLE];
	wire infrared_codec_enable = serial_mode_config_q[`USF_M_INFRARED];
	wire loopback_select = serial_mode_config_q[`USF_M_LOOPBACK];
	wire auto_baud_enable = serial_mode_config_q[`USF_M_AUTOBAUD];
	wire rx_polarity_invert = serial_mode_config_q[`USF_M_RXINV];
	wire high_speed_select = serial_mode_config_q[`USF_M_HISPEED];
	wire [1:0] parity_data_select = serial_mode_config_q[`USF_M_PD_HI:`USF_M_PD_LO];
	wire stop_bit_select = serial_mode_config_q[`USF_M_TWOSTOP];
	wire [1:0] tx_interrupt_mode = {serial_status_control_q[`USF_S_TXI_HI],
		serial_status_control_q[`USF_S_TXI_LO]};
	wire tx_polarity_invert = serial_status_control_q[`USF_S_TXINV];
	wire break_request = serial_status_control_q[`USF_S_BREAK];
	wire transmit_enable = serial_status_control_q[`USF_S_TXEN];
	wire [1:0] rx_interrupt_mode = serial_status_control_q[`USF_S_RXI_HI:`USF_S_RXI_LO];
	wire address_detect_enable = serial_status_control_q[`USF_S_ADDRDET];
	wire nine_bit = (parity_data_select == `USF_PD_NINE);

	// register decode
	wire wr_mode = reg_we && (reg_addr == `USF_ADDR_MODE);
	wire wr_status = reg_we && (reg_addr == `USF_ADDR_STATUS);
	wire wr_tx = reg_we && (reg_addr == `USF_ADDR_TXDATA);
	wire wr_div = reg_we && (reg_addr == `USF_ADDR_DIVISOR);
	wire rd_rx = reg_re && (reg_addr == `USF_ADDR_RXDATA);

	// baud generator: one tick per divisor+1 clocks
	wire baud_tick = module_enable && (bcnt_q == divisor_q);
	wire [4:0] os_last = (high_speed_select ? `USF_OS_HIGH : `USF_OS_STD) - 5'd1; // [RULE2]
	wire ir_on = infrared_codec_enable && !high_speed_select; // [RULE5]

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !module_enable || baud_tick)
			bcnt_q <= 16'h0000;
		else
			bcnt_q <= bcnt_q + 16'h0001;
	end

	// transmitter
	wire tx_go = module_enable && transmit_enable; // [RULE9] [RULE21]
	wire tx_idle = (tx_st_q == usf_pkg::TX_IDLE);
	wire tx_start_brk = tx_go && tx_idle && break_request; // [RULE8]
	wire tx_pop = tx_go && tx_idle && !break_request && tx_fifo_valid;
	wire tx_os_end = (tx_st_q == usf_pkg::TX_SHIFT) && baud_tick && (tx_os_q == os_last);
	wire tx_done = tx_os_end && (tx_bit_q == tx_len_q - 4'd1);
	wire tx_line = tx_idle ? 1'b1 : tx_sh_q[0];
	wire tx_buffer_full = !tx_in_ready; // [RULE10]
	wire transmitter_empty = !tx_fifo_valid && tx_idle; // [RULE11]
	wire brk_clr = tx_done && tx_brk_q; // [RULE8]
	// infrared pulse covers the first 3/16 of every zero bit
	wire ir_pulse_tx = !tx_line && (tx_os_q < `USF_IR_PULSE);
	wire tx_pin_d = (ir_on ? ir_pulse_tx : tx_line) ^ tx_polarity_invert; // [RULE7]
	wire tx_irq_d = (tx_pop && (tx_interrupt_mode == `USF_TXI_EACH)) // [RULE6]
		|| (tx_pop && (tx_interrupt_mode == `USF_TXI_EMPTY) && (tx_count == CW'(1)))
		|| (tx_done && (tx_interrupt_mode == `USF_TXI_DONE) && !tx_fifo_valid);

	usf_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo ( // [RULE19]
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.flush(!tx_go), // [RULE9]
		.in_valid(wr_tx && tx_go),
		.in_ready(tx_in_ready),
		.in_data(reg_wdata[8:0]),
		.out_valid(tx_fifo_valid),
		.out_ready(tx_pop),
		.out_data(tx_head),
		.count(tx_count)
	);

	always_comb
	begin
		tx_st_d = tx_st_q;
		case (tx_st_q)
			usf_pkg::TX_IDLE:
				if (tx_start_brk || tx_pop)
					tx_st_d = usf_pkg::TX_SHIFT;
			usf_pkg::TX_SHIFT:
				if (tx_done)
					tx_st_d = usf_pkg::TX_IDLE;
			default:
				tx_st_d = usf_pkg::TX_IDLE;
		endcase
		if (!tx_go)
			tx_st_d = usf_pkg::TX_IDLE; // [RULE9]
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !tx_go || tx_start_brk || tx_pop || tx_os_end)
			tx_os_q <= 5'd0;
		else if ((tx_st_q == usf_pkg::TX_SHIFT) && baud_tick)
			tx_os_q <= tx_os_q + 5'd1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !tx_go)
		begin
			tx_bit_q <= 4'd0;
			tx_sh_q <= 15'h7fff;
			tx_len_q <= 4'd0;
			tx_brk_q <= 1'b0;
		end
		else if (tx_start_brk || tx_pop)
		begin
			tx_bit_q <= 4'd0;
			tx_sh_q <= build_frame(tx_head, parity_data_select, tx_start_brk); // [RULE3]
			tx_len_q <= frame_len(parity_data_select, stop_bit_select, tx_start_brk); // [RULE4]
			tx_brk_q <= tx_start_brk;
		end
		else if (tx_os_end)
		begin
			tx_bit_q <= tx_bit_q + 4'd1;
			tx_sh_q <= {1'b1, tx_sh_q[14:1]};
		end
	end

	always_ff @(posedge clk_sys)
	begin
		tx_st_q <= sys_rst ? usf_pkg::TX_IDLE : tx_st_d;
		tx_pin_q <= sys_rst ? 1'b1 : tx_pin_d;
		tx_oe_q <= sys_rst ? 1'b0 : tx_go;
		tx_irq_q <= sys_rst ? 1'b0 : tx_irq_d;
	end

	// receiver input: infrared pulses are stretched to a full bit
	wire rx_pin_lvl = rx_pin_i ^ rx_polarity_invert; // [RULE1]
	wire ir_seen = (rx_pin_i != rx_polarity_invert);
	wire ir_dec = !ir_seen && (ir_hold_q == 4'h0);
	wire rx_n = loopback_select ? tx_line : (ir_on ? ir_dec : rx_pin_lvl); // [RULE22]

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !ir_on)
			ir_hold_q <= 4'h0;
		else if (ir_seen)
			ir_hold_q <= `USF_IR_HOLD;
		else if (baud_tick && (ir_hold_q != 4'h0))
			ir_hold_q <= ir_hold_q - 4'h1;
	end

	// receiver framing
	wire rx_on = module_enable && !auto_baud_enable;
	wire [3:0] rx_len = (parity_data_select == `USF_PD_PLAIN) ? 4'd9 : 4'd10; // [RULE3]
	wire rx_mid = baud_tick && (rx_os_q == {1'b0, os_last[4:1]});
	wire rx_samp = (rx_st_q == usf_pkg::RX_DATA) && baud_tick && (rx_os_q == os_last); // [RULE23]
	wire rx_done = rx_samp && (rx_bit_q == rx_len - 4'd1);
	wire [8:0] rx_word = nine_bit ? rx_sh_q : {1'b0, rx_sh_q[7:0]};
	wire rx_has_par = (parity_data_select == `USF_PD_ODD) || (parity_data_select == `USF_PD_EVEN);
	wire rx_parity_error = rx_has_par
		&& (rx_sh_q[8] != calc_parity(rx_sh_q[7:0], parity_data_select == `USF_PD_ODD));
	wire rx_framing_error = !rx_n; // [RULE24]
	wire rx_accept = !(address_detect_enable && nine_bit && !rx_sh_q[8]); // [RULE13]
	wire rx_push = rx_done && rx_accept;
	wire overrun_set = rx_push && !rx_in_ready; // [RULE17]
	// clear only on a 1 -> 0 write; a new overflow in the same cycle wins
	wire overrun_clr = wr_status && !reg_wdata[`USF_S_OVERRUN] && overrun_q && !overrun_set;
	wire rx_flush = overrun_clr || !module_enable; // [RULE17]
	wire [CW-1:0] rx_count_next = rx_count + CW'(1);
	wire rx_irq_d = rx_push && rx_in_ready && ( // [RULE12]
		!rx_interrupt_mode[1]
		|| ((rx_interrupt_mode == `USF_RXI_FULL) && (rx_count_next == CW'(`USF_RX_THR_FULL)))
		|| ((rx_interrupt_mode == `USF_RXI_3Q) && (rx_count_next == CW'(`USF_RX_THR_3Q))));
	wire receiver_idle = (rx_st_q == usf_pkg::RX_IDLE); // [RULE14]

	usf_fifo #(
		.WIDTH(11),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo ( // [RULE19]
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.flush(rx_flush),
		.in_valid(rx_push),
		.in_ready(rx_in_ready),
		.in_data({rx_parity_error, rx_framing_error, rx_word}),
		.out_valid(rx_fifo_valid),
		.out_ready(rd_rx),
		.out_data(rx_head),
		.count(rx_count)
	);

	always_comb
	begin
		rx_st_d = rx_st_q;
		case (rx_st_q)
			// edge, not level: a low line left by a bad stop bit is no new start
			usf_pkg::RX_IDLE:
				if (rx_prev_q && !rx_n)
					rx_st_d = usf_pkg::RX_START; // [RULE23]
			usf_pkg::RX_START:
				if (rx_mid)
					rx_st_d = rx_n ? usf_pkg::RX_IDLE : usf_pkg::RX_DATA;
			usf_pkg::RX_DATA:
				if (rx_done)
					rx_st_d = usf_pkg::RX_IDLE;
			default:
				rx_st_d = usf_pkg::RX_IDLE;
		endcase
		if (!rx_on || rx_flush)
			rx_st_d = usf_pkg::RX_IDLE; // [RULE21]
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			rx_st_q <= usf_pkg::RX_IDLE;
		else
			rx_st_q <= rx_st_d;
		if (sys_rst || receiver_idle || (rx_st_d != rx_st_q) || rx_samp)
			rx_os_q <= 5'd0;
		else if (baud_tick)
			rx_os_q <= rx_os_q + 5'd1;
		if (sys_rst || (rx_st_q != usf_pkg::RX_DATA))
			rx_bit_q <= 4'd0;
		else if (rx_samp)
			rx_bit_q <= rx_bit_q + 4'd1;
		if (rx_samp && (rx_bit_q < 4'd9))
			rx_sh_q[rx_bit_q] <= rx_n;
		rx_prev_q <= sys_rst ? 1'b1 : rx_n;
		overrun_q <= sys_rst ? 1'b0 : (overrun_set || (overrun_q && !overrun_clr));
		rx_irq_q <= sys_rst ? 1'b0 : rx_irq_d;
	end

	// auto-baud: five falling edges of a 55h sync span eight bit times
	wire ab_fall = module_enable && auto_baud_enable && rx_prev_q && !rx_n;
	wire ab_done = ab_fall && (ab_falls_q == `USF_SYNC_FALLS - 3'd1); // [RULE20]
	wire [23:0] ab_span = ab_cnt_q + 24'h000001;
	wire [15:0] ab_quot = high_speed_select ? 16'(ab_span >> `USF_SYNC_SHIFT_HIGH)
		: 16'(ab_span >> `USF_SYNC_SHIFT_STD);
	wire [15:0] ab_div = (ab_quot == 16'h0000) ? 16'h0000 : ab_quot - 16'h0001;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !auto_baud_enable || !module_enable || ab_done)
			ab_falls_q <= 3'd0;
		else if (ab_fall)
			ab_falls_q <= ab_falls_q + 3'd1;
		if (sys_rst || (ab_falls_q == 3'd0))
			ab_cnt_q <= 24'h000000;
		else
			ab_cnt_q <= ab_cnt_q + 24'h000001;
	end

	// register file
	always_comb
	begin
		serial_mode_config_d = serial_mode_config_q;
		if (wr_mode)
			serial_mode_config_d = reg_wdata & `USF_MODE_WMASK;
		else if (ab_done)
			serial_mode_config_d[`USF_M_AUTOBAUD] = 1'b0; // [RULE20]
		serial_status_control_d = serial_status_control_q;
		if (wr_status)
			serial_status_control_d = reg_wdata & `USF_STATUS_WMASK;
		else if (brk_clr)
			serial_status_control_d[`USF_S_BREAK] = 1'b0; // [RULE8]
		divisor_d = divisor_q;
		if (wr_div)
			divisor_d = reg_wdata;
		else if (ab_done)
			divisor_d = ab_div; // [RULE20]
	end

	// status bits: 9 full, 8 empty, 4 idle, 3 parity, 2 framing, 1 overrun, 0 available
	// error bits only describe a character that is really at the head
	wire head_parity_error = rx_fifo_valid && rx_head[10];
	wire head_framing_error = rx_fifo_valid && rx_head[9];
	wire [15:0] status_word = serial_status_control_q | {6'b000000, tx_buffer_full,
		transmitter_empty, 3'b000, receiver_idle, head_parity_error, head_framing_error, overrun_q,
		rx_fifo_valid}; // [RULE15] [RULE16] [RULE18]

	always_comb
	begin
		if (reg_addr == `USF_ADDR_MODE)
			rd_word = serial_mode_config_q;
		else if (reg_addr == `USF_ADDR_STATUS)
			rd_word = status_word;
		else if (reg_addr == `USF_ADDR_RXDATA)
			rd_word = {7'b0000000, rx_head[8:0]};
		else if (reg_addr == `USF_ADDR_DIVISOR)
			rd_word = divisor_q;
		else
			rd_word = 16'h0000;
	end

	always_ff @(posedge clk_sys)
	begin
		serial_mode_config_q <= sys_rst ? `USF_MODE_RESET : serial_mode_config_d;
		serial_status_control_q <= sys_rst ? `USF_STATUS_RESET : serial_status_control_d;
		divisor_q <= sys_rst ? `USF_DIVISOR_RESET : divisor_d;
		rdata_q <= (sys_rst || !reg_re) ? 16'h0000 : rd_word;
	end

	assign reg_rdata = rdata_q;
	assign tx_pin_o = tx_pin_q;
	assign tx_pin_oe = tx_oe_q;
	assign rx_pin_owned = module_enable; // [RULE21]
	assign pin_enable_field = serial_mode_config_q[`USF_M_PINS_HI:`USF_M_PINS_LO];
	assign tx_irq = tx_irq_q;
	assign rx_irq = rx_irq_q;

	sequence s_brk_start;
		tx_start_brk;
	endsequence
	sequence s_brk_end;
		tx_done && tx_brk_q;
	endsequence

	property p_tx_disable;
		!tx_go |=> (tx_count == '0) && tx_idle && !tx_pin_oe;
	endproperty
	a_tx_disable: assert property (p_tx_disable) else $error("transmit disable not honoured"); // [RULE9]
	property p_tx_full;
		tx_buffer_full |-> (tx_count == CW'(FIFO_DEPTH));
	endproperty
	a_tx_full: assert property (p_tx_full) else $error("buffer full flag wrong"); // [RULE10]
	property p_transmitter_empty_fall;
		$fell(transmitter_empty) |-> $past(wr_tx) || $past(tx_start_brk);
	endproperty
	a_transmitter_empty_fall: assert property (p_transmitter_empty_fall) else $error("empty flag fell without cause"); // [RULE11]
	property p_break_frame;
		s_brk_start |=> (tx_len_q == 4'd14) && (tx_sh_q[12:0] == 13'h0000) && tx_sh_q[13];
	endproperty
	a_break_frame: assert property (p_break_frame) else $error("break frame malformed"); // [RULE8]
	property p_break_clear;
		s_brk_end |=> !break_request || $past(wr_status);
	endproperty
	a_break_clear: assert property (p_break_clear) else $error("break request not cleared"); // [RULE8]
	property p_os_ratio;
		module_enable |-> (os_last == (high_speed_select ? 5'd3 : 5'd15));
	endproperty
	a_os_ratio: assert property (p_os_ratio) else $error("oversampling ratio wrong"); // [RULE2]
	property p_overrun_flush;
		overrun_clr |=> (rx_count == '0) && receiver_idle && !overrun_q;
	endproperty
	a_overrun_flush: assert property (p_overrun_flush) else $error("overrun clear no flush"); // [RULE17]
	property p_rx_avail;
		(rx_push && rx_in_ready) |=> rx_fifo_valid && (rx_count != '0);
	endproperty
	a_rx_avail: assert property (p_rx_avail) else $error("data available not set"); // [RULE18]
	property p_rx_busy;
		(receiver_idle && rx_on && rx_prev_q && !rx_n) |=> !receiver_idle;
	endproperty
	a_rx_busy: assert property (p_rx_busy) else $error("receiver idle while busy"); // [RULE14]
	property p_rx_irq_full;
		(rx_irq_d && (rx_interrupt_mode == 2'b11) && !rd_rx) |=> (rx_count == CW'(4)) && rx_irq;
	endproperty
	a_rx_irq_full: assert property (p_rx_irq_full) else $error("full interrupt at wrong fill"); // [RULE12]
	property p_autobaud;
		(ab_done && !wr_mode && !wr_div) |=> !auto_baud_enable && (divisor_q == $past(ab_div));
	endproperty
	a_autobaud: assert property (p_autobaud) else $error("auto-baud did not complete"); // [RULE20]
endmodule

// ==== verif/usf_remote_node.sv ====
module usf_remote_node (
	// serial lines, seen from the remote side
	input wire logic clk_sys,
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int bit_clks = 16;
	// idle high, as a pull-up would leave it
	initial line_out = 1'b1;
	// frame given whole, start bit first; same rate and format as the block
	task automatic send(input logic [13:0] bits, input int n);
		@(posedge clk_sys);
		for (int i = 0; i < n; i++)
		begin
			line_out <= bits[i];
			repeat (bit_clks) @(posedge clk_sys);
		end
		line_out <= 1'b1;
	endtask
	// poll for the start edge, then sample each bit near its centre
	task automatic grab(output logic [13:0] bits, input int n);
		int t;
		bits = '0;
		t = 0;
		while (line_in !== 1'b0 && t < 2000)
		begin
			@(posedge clk_sys);
			t++;
		end
		repeat (bit_clks / 2) @(posedge clk_sys);
		for (int i = 0; i < n; i++)
		begin
			bits[i] = line_in;
			repeat (bit_clks) @(posedge clk_sys);
		end
	endtask
endmodule

// ==== verif/tb_uart_frame_status_control.sv ====
`include "usf_params.svh"
module tb_uart_frame_status_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys;
	logic sys_rst;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_we;
	logic reg_re;
	logic [15:0] reg_rdata;
	logic rx_line;
	logic tx_pin_o;
	logic tx_pin_oe;
	logic rx_pin_owned;
	logic tx_irq;
	logic rx_irq;
	wire logic tx_line;
	int bad_count;
	int check_count;
	int tx_irqs;
	int rx_irqs;
	logic [15:0] s;
	logic [13:0] b;
	logic [15:0] c_mode [6] = '{16'h8000, 16'h8004, 16'h8002, 16'h8006, 16'h8006, 16'h8000};
	logic [15:0] c_stat [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0020, 16'h0000};
	logic [13:0] c_frame [6] = '{14'h0278, 14'h0478, 14'h0478, 14'h0678, 14'h0478, 14'h0078};
	int c_n [6] = '{10, 11, 11, 11, 11, 10};
	logic [15:0] c_exps [6] = '{16'h0111, 16'h0119, 16'h0111, 16'h0111, 16'h0130, 16'h0115};
	logic [15:0] c_data [6] = '{16'h003c, 16'h003c, 16'h003c, 16'h013c, 16'h0000, 16'h003c};
	// released tx pin reads high through its pull-up
	assign tx_line = tx_pin_oe ? tx_pin_o : 1'b1;
	usf_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.rx_pin_i(rx_line), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
		.rx_pin_owned(rx_pin_owned), .pin_enable_field(), .tx_irq(tx_irq), .rx_irq(rx_irq));
	usf_remote_node u_node (.clk_sys(clk_sys), .line_in(tx_line), .line_out(rx_line));
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		if (tx_irq === 1'b1) tx_irqs++;
		if (rx_irq === 1'b1) rx_irqs++;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// whole run is a few thousand bit clocks; this allows several times that
	initial
	begin
		#400000;
		bad_count++;
		final_report();
	end
	initial
	begin
		sys_rst = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(`USF_ADDR_MODE, s);
		chk("mode reset", s, `USF_MODE_RESET);
		rd(`USF_ADDR_STATUS, s);
		chk("status reset", s, 16'h0110);
		rd(`USF_ADDR_DIVISOR, s);
		chk("divisor reset", s, `USF_DIVISOR_RESET);
		rd(4'hf, s);
		chk("unmapped read", s, 16'h0000);
		wr(`USF_ADDR_MODE, 16'h8000);
		wr(`USF_ADDR_STATUS, 16'h0400);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("tx drive", {15'h0, tx_pin_oe}, 16'h0001);
		chk("rx owned", {15'h0, rx_pin_owned}, 16'h0001);
		tx_irqs = 0;
		fork
			u_node.grab(b, 10);
			wr(`USF_ADDR_TXDATA, 16'h00a5);
		join
		chk("tx frame", {2'h0, b}, 16'h034a);
		chk("tx irq each", tx_irqs[15:0], 16'h0001);
		// two queued chars: a single stop would put the next start in bit 10
		wr(`USF_ADDR_MODE, 16'h8009);
		u_node.bit_clks = 4;
		fork
			u_node.grab(b, 11);
			begin
				wr(`USF_ADDR_TXDATA, 16'h005a);
				wr(`USF_ADDR_TXDATA, 16'h005a);
			end
		join
		chk("tx frame 4x", {2'h0, b}, 16'h06b4);
		repeat (60) @(posedge clk_sys);
		wr(`USF_ADDR_MODE, 16'h8000);
		u_node.bit_clks = 16;
		fork
			u_node.grab(b, 14);
			wr(`USF_ADDR_STATUS, 16'h0c00);
		join
		chk("break frame", {2'h0, b}, 16'h2000);
		rd(`USF_ADDR_STATUS, s);
		chk("break cleared", s, 16'h0510);
		wr(`USF_ADDR_STATUS, 16'h4400);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("tx idle inverted", {15'h0, tx_pin_o}, 16'h0000);
		wr(`USF_ADDR_STATUS, 16'h0400);
		for (int i = 0; i < 5; i++)
			wr(`USF_ADDR_TXDATA, 16'h0011);
		rd(`USF_ADDR_STATUS, s);
		chk("tx full", s, 16'h0610);
		wr(`USF_ADDR_STATUS, 16'h0000);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("tx released", {15'h0, tx_pin_oe}, 16'h0000);
		rd(`USF_ADDR_STATUS, s);
		chk("tx aborted", s, 16'h0110);
		wr(`USF_ADDR_STATUS, 16'h00c0);
		rx_irqs = 0;
		for (int i = 0; i < 5; i++)
			u_node.send(14'h0278, 10);
		repeat (8) @(posedge clk_sys);
		rd(`USF_ADDR_STATUS, s);
		chk("overrun set", s, 16'h01d3);
		chk("rx irq full", rx_irqs[15:0], 16'h0001);
		wr(`USF_ADDR_STATUS, 16'h00c0);
		rd(`USF_ADDR_STATUS, s);
		chk("overrun flush", s, 16'h01d0);
		rx_irqs = 0;
		for (int k = 0; k < 6; k++)
		begin
			wr(`USF_ADDR_MODE, c_mode[k]);
			wr(`USF_ADDR_STATUS, c_stat[k]);
			fork
				u_node.send(c_frame[k], c_n[k]);
				begin
					repeat (40) @(posedge clk_sys);
					rd(`USF_ADDR_STATUS, s);
					chk("receiver busy", {15'h0, s[4]}, 16'h0000);
				end
			join
			repeat (8) @(posedge clk_sys);
			rd(`USF_ADDR_STATUS, s);
			chk("rx status", s, c_exps[k]);
			if (c_exps[k][0] === 1'b1)
			begin
				rd(`USF_ADDR_RXDATA, s);
				chk("rx data", s, c_data[k]);
			end
		end
		chk("rx irq each", rx_irqs[15:0], 16'h0005);
		wr(`USF_ADDR_MODE, 16'h8040);
		wr(`USF_ADDR_STATUS, 16'h0400);
		wr(`USF_ADDR_TXDATA, 16'h003c);
		repeat (200) @(posedge clk_sys);
		rd(`USF_ADDR_STATUS, s);
		chk("loopback status", s, 16'h0511);
		rd(`USF_ADDR_RXDATA, s);
		chk("loopback data", s, 16'h003c);
		final_report();
	end
endmodule
